// ==== verilog/blc_core.sv ====
// landing-marker enforcement unit with legacy page-map fallback
module blc_core
   import blc_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          rst_b,
   input  blc_instr_s         instr,
   input  wire logic [1:0]    current_priv_level,
   input  blc_ctrl_s          user_ctrl,
   input  blc_ctrl_s          sup_ctrl,
   input  wire logic          global_flow_protect_enable,
   input  wire logic          long_mode_active,
   input  wire logic          code64,
   input  wire logic          five_level_paging,
   input  wire logic          enclave_mode,
   input  wire logic          enclave_opt_in,
   input  wire logic [63:0]   enclave_base_addr,
   input  wire logic [63:0]   linear_instr_pointer,
   input  wire logic [63:0]   legacy_page_map_base,
   input  wire logic          ld_done,
   input  wire logic          ld_fault,
   input  wire logic [7:0]    ld_data,
   output blc_ld_s            ld_req_ff,
   output blc_fault_e         fault_ff,
   output logic [7:0]         fault_code_ff,
   output logic               restart_ff,
   output logic               irq_window_block_ff,
   output logic               global_flow_clear_ff,
   output logic               spec_stall_ff,
   output blc_trk_s           user_trk_ff,
   output blc_trk_s           sup_trk_ff
);
   // =====================================================================
   // privilege select
   logic      is_user;
   blc_ctrl_s ctl;
   blc_trk_s  trk;
   assign is_user = (current_priv_level == PRIV_USER);
   assign ctl     = is_user ? user_ctrl : sup_ctrl;
   assign trk     = is_user ? user_trk_ff : sup_trk_ff;

   logic       track_on;
   assign track_on = global_flow_protect_enable & ctl.tracking_enable;

   // =====================================================================
   // lookup sequencer state
   blc_state_e st_ff;
   blc_state_e nxt_st;
   logic       lk_user_ff;
   logic [2:0] lk_bit_ff;

   // =====================================================================
   // violation detect and fault choice
   logic viol;
   logic bp_enclave_out;
   logic start_lookup;
   blc_fault_e nxt_fault;
   logic [7:0] nxt_code;
   logic       bp_here;
   assign bp_here        = instr.valid & instr.breakpoint_instr;
   // opt-out enclave drops special breakpoint treatment
   assign bp_enclave_out = enclave_mode & ~enclave_opt_in;
   assign viol = instr.valid & track_on & trk.awaiting_landing & ~trk.tracking_paused
                 & ~instr.landing_marker_instr & ~(bp_here & ~bp_enclave_out)
                 & (st_ff == BLC_ST_IDLE);
   assign start_lookup = viol & ctl.legacy_treatment_enable;

   // priority: debug traps, code bp, bp, missing marker, nm, ud, gd
   always_comb begin
      nxt_fault = BLC_FLT_NONE;
      nxt_code  = GP_CODE_ZERO;
      if (instr.valid) begin
         if (instr.dbg_trap_pend) begin
            nxt_fault = BLC_FLT_DBTRAP;
         end else if (instr.code_bp_pend) begin
            nxt_fault = BLC_FLT_CODEBP;
         end else if (bp_here & ~bp_enclave_out) begin
            nxt_fault = BLC_FLT_BP;
            nxt_code  = BP_VECTOR; // enclave: fault class, no gate
         end else if (viol & ~ctl.legacy_treatment_enable) begin
            nxt_fault = BLC_FLT_CP;
         end else if (viol) begin
            nxt_fault = BLC_FLT_NONE; // decided after lookup
         end else if (bp_here) begin
            nxt_fault = BLC_FLT_UD; // opt-out enclave: an opcode fault, below missing marker
         end else if (instr.acm_exit & global_flow_protect_enable) begin
            nxt_fault = BLC_FLT_GP;
         end else if (instr.nm_pend) begin
            nxt_fault = BLC_FLT_NM;
         end else if (instr.ud_pend) begin
            nxt_fault = BLC_FLT_UD;
         end else if (instr.gd_pend) begin
            nxt_fault = BLC_FLT_GD;
         end
      end
   end

   // =====================================================================
   // lookup address: slice selected by mode, enclave relative
   logic [63:0] la;
   logic [63:0] la_idx;
   logic [63:0] nxt_addr;
   assign la = enclave_mode ? (linear_instr_pointer - enclave_base_addr)
                            : linear_instr_pointer;
   always_comb begin
      la_idx = '0;
      if (!(long_mode_active & code64)) begin
         la_idx[LA_HI_LEGACY-LA_LO_BIT:0] = la[LA_HI_LEGACY:LA_LO_BIT];
      end else if (!five_level_paging) begin
         la_idx[LA_HI_LONG4-LA_LO_BIT:0] = la[LA_HI_LONG4:LA_LO_BIT];
      end else begin
         la_idx[LA_HI_LONG5-LA_LO_BIT:0] = la[LA_HI_LONG5:LA_LO_BIT];
      end
   end
   assign nxt_addr = legacy_page_map_base + la_idx;

   // =====================================================================
   // sequencer: issue one byte load, wait for data or fault
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         BLC_ST_IDLE:  if (start_lookup) nxt_st = BLC_ST_ISSUE;
         BLC_ST_ISSUE: nxt_st = BLC_ST_WAIT;
         BLC_ST_WAIT:  if (ld_done | ld_fault) nxt_st = BLC_ST_IDLE;
         default:      nxt_st = BLC_ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= BLC_ST_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // capture lookup context at the violation
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         lk_user_ff <= 1'b0;
         lk_bit_ff  <= '0;
      end else if (start_lookup) begin
         lk_user_ff <= is_user;
         lk_bit_ff  <= la[LA_SEL_HI:LA_SEL_LO];
      end
   end

   // load request: size from long mode, privilege for permission check
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ld_req_ff <= '0;
      end else begin
         ld_req_ff.valid <= start_lookup;
         if (start_lookup) begin
            ld_req_ff.addr   <= long_mode_active ? nxt_addr : 64'(nxt_addr[LA_HI_LEGACY:0]);
            ld_req_ff.addr64 <= long_mode_active;
            ld_req_ff.priv   <= current_priv_level;
         end
      end
   end

   // =====================================================================
   // lookup outcome
   logic lk_resolve;
   logic lk_allow;
   logic lk_deny;
   logic lk_pf;
   blc_ctrl_s lk_ctl;
   assign lk_resolve = (st_ff == BLC_ST_WAIT);
   assign lk_ctl     = lk_user_ff ? user_ctrl : sup_ctrl;
   assign lk_pf      = lk_resolve & ld_fault;
   assign lk_allow   = lk_resolve & ld_done & ~ld_fault & ld_data[lk_bit_ff];
   assign lk_deny    = lk_resolve & ld_done & ~ld_fault & ~ld_data[lk_bit_ff];

   // fault report, one cycle pulse
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_ff      <= BLC_FLT_NONE;
         fault_code_ff <= '0;
      end else if (lk_pf) begin
         fault_ff      <= BLC_FLT_PF; // tracker left awaiting
         fault_code_ff <= '0;
      end else if (lk_deny) begin
         fault_ff      <= BLC_FLT_CP;
         fault_code_ff <= '0;
      end else begin
         fault_ff      <= nxt_fault;
         fault_code_ff <= nxt_code;
      end
   end

   // restart with interrupt window held shut on an allowed transfer
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         restart_ff          <= 1'b0;
         irq_window_block_ff <= 1'b0;
      end else begin
         restart_ff          <= lk_allow;
         irq_window_block_ff <= lk_allow | (st_ff != BLC_ST_IDLE);
      end
   end

   // global enable clear request on secure entry; never restored here
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         global_flow_clear_ff <= 1'b0;
      end else begin
         global_flow_clear_ff <= instr.valid & instr.acm_entry;
      end
   end

   // =====================================================================
   // tracker update terms per privilege
   logic arm;
   logic land;
   logic xabort;
   logic rearm;
   assign xabort = instr.valid & instr.xact_abort;
   // paused trackers stay idle on indirect branches
   assign arm  = instr.valid & track_on & ~trk.tracking_paused & instr.indirect_branch
                 & ~instr.no_track_prefix & ~trk.awaiting_landing;
   assign rearm = instr.valid & instr.irq_return_dbg & track_on & ~trk.tracking_paused;
   assign land = instr.valid & instr.landing_marker_instr & track_on;

   logic u_await;
   logic s_await;
   logic u_idle;
   logic s_idle;
   logic u_pset;
   logic s_pset;
   logic u_pclr;
   logic s_pclr;
   assign u_await = is_user & (arm | rearm);
   assign s_await = ~is_user & (arm | rearm);
   assign u_idle  = xabort | (is_user & land) | (lk_allow & lk_user_ff);
   assign s_idle  = xabort | (~is_user & land) | (lk_allow & ~lk_user_ff);
   assign u_pset  = lk_allow & lk_user_ff & ~user_ctrl.no_pause_ctrl;
   assign s_pset  = lk_allow & ~lk_user_ff & ~sup_ctrl.no_pause_ctrl;
   assign u_pclr  = xabort | (is_user & land);
   assign s_pclr  = xabort | (~is_user & land);

   blc_trk_slot u_user_slot (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .set_await (u_await),
      .go_idle   (u_idle),
      .set_pause (u_pset),
      .clr_pause (u_pclr),
      .trk_ff    (user_trk_ff)
   );

   blc_trk_slot u_sup_slot (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .set_await (s_await),
      .go_idle   (s_idle),
      .set_pause (s_pset),
      .clr_pause (s_pclr),
      .trk_ff    (sup_trk_ff)
   );

   // =====================================================================
   // speculation limiter while awaiting a marker
   logic [3:0] spec_i_ff;
   logic [3:0] spec_l_ff;
   logic       spec_arm;
   logic       spec_cnt;
   logic [3:0] nxt_spec_i;
   logic [3:0] nxt_spec_l;
   assign spec_arm = track_on & trk.awaiting_landing & ~trk.tracking_paused;
   // stall is judged on the next counts so the limit is never overshot
   assign spec_cnt   = instr.valid & ~instr.landing_marker_instr & ~spec_stall_ff;
   assign nxt_spec_i = spec_i_ff + {3'h0, spec_cnt};
   assign nxt_spec_l = spec_l_ff + {3'h0, spec_cnt & instr.is_load};
   // counters restart whenever the tracker leaves awaiting
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         spec_i_ff <= '0;
         spec_l_ff <= '0;
      end else if (!spec_arm) begin
         spec_i_ff <= '0;
         spec_l_ff <= '0;
      end else begin
         spec_i_ff <= nxt_spec_i;
         spec_l_ff <= nxt_spec_l;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         spec_stall_ff <= 1'b0;
      end else begin
         spec_stall_ff <= spec_arm & ((nxt_spec_i >= SPEC_MAX_INSTR)
                          | (nxt_spec_l >= SPEC_MAX_LOADS));
      end
   end

   // =====================================================================
   // checks
   AST_LOAD_AFTER_VIOL: assert property (@(posedge ref_clk) disable iff (!rst_b)
      start_lookup |=> ld_req_ff.valid && ld_req_ff.addr64 == $past(long_mode_active))
      else $error("map load not issued after violation");
   AST_CP_NO_LEGACY: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (viol && !ctl.legacy_treatment_enable && !instr.dbg_trap_pend && !instr.code_bp_pend)
      |=> fault_ff == BLC_FLT_CP)
      else $error("missing-marker fault not raised without legacy enable");
   AST_BP_BEATS_CP: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (bp_here && !bp_enclave_out && !instr.dbg_trap_pend && !instr.code_bp_pend)
      |=> fault_ff == BLC_FLT_BP)
      else $error("breakpoint not delivered first");
   AST_OPTOUT_UD: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (bp_here && bp_enclave_out && !viol && !instr.dbg_trap_pend && !instr.code_bp_pend)
      |=> fault_ff == BLC_FLT_UD)
      else $error("opt-out enclave breakpoint not undefined-opcode");
   AST_PRIV_PASSED: assert property (@(posedge ref_clk) disable iff (!rst_b)
      start_lookup |=> ld_req_ff.priv == $past(current_priv_level))
      else $error("load privilege differs from current level");
   AST_ALLOW_RESTART: assert property (@(posedge ref_clk) disable iff (!rst_b)
      lk_allow |=> restart_ff && irq_window_block_ff)
      else $error("allowed transfer did not restart");
   AST_PF_KEEPS_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (lk_pf && !xabort) |=> fault_ff == BLC_FLT_PF
      && (lk_user_ff ? user_trk_ff.awaiting_landing : sup_trk_ff.awaiting_landing))
      else $error("lookup fault lost awaiting state");
   AST_ABORT_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      xabort |=> user_trk_ff == '0 && sup_trk_ff == '0)
      else $error("abort did not idle tracker");
   AST_PAUSE_SET: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (lk_allow && lk_user_ff && !xabort && !(is_user && land)) |=>
      user_trk_ff.tracking_paused == !$past(user_ctrl.no_pause_ctrl))
      else $error("pause flag wrong after allowed transfer");
   AST_GP_EXIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (instr.valid && instr.acm_exit && global_flow_protect_enable && nxt_fault == BLC_FLT_GP)
      |=> fault_ff == BLC_FLT_GP && fault_code_ff == GP_CODE_ZERO)
      else $error("exit with enable set did not fault");
   AST_SPEC_LOADS: assert property (@(posedge ref_clk) disable iff (!rst_b)
      spec_l_ff <= SPEC_MAX_LOADS)
      else $error("speculative loads above limit");
   AST_SPEC_INSTR: assert property (@(posedge ref_clk) disable iff (!rst_b)
      spec_i_ff <= SPEC_MAX_INSTR)
      else $error("speculative instructions above limit");
   COV_ALLOW: cover property (@(posedge ref_clk) disable iff (!rst_b) lk_allow);
   COV_DENY: cover property (@(posedge ref_clk) disable iff (!rst_b) lk_deny);
   COV_PF: cover property (@(posedge ref_clk) disable iff (!rst_b) lk_pf);
   COV_STALL: cover property (@(posedge ref_clk) disable iff (!rst_b) spec_stall_ff);
endmodule

// ==== common/blc_pkg.sv ====
// shared types and constants for the landing-marker enforcement unit
package blc_pkg;
   // =====================================================================
   // address slices and widths
   localparam int LA_W          = 64;
   localparam int LA_LO_BIT     = 15; // byte index starts above page-in-byte bits
   localparam int LA_HI_LEGACY  = 31;
   localparam int LA_HI_LONG4   = 47;
   localparam int LA_HI_LONG5   = 56;
   localparam int LA_SEL_HI     = 14;
   localparam int LA_SEL_LO     = 12; // 4K page granule
   localparam int USER_PRIV     = 3;
   localparam logic [1:0] PRIV_USER = 2'h3;
   localparam logic [7:0] GP_CODE_ZERO = 8'h00;
   localparam logic [7:0] BP_VECTOR    = 8'h03;
   // speculation limits past a missing marker
   localparam logic [3:0] SPEC_MAX_INSTR = 4'h7; // fewer than 8
   localparam logic [3:0] SPEC_MAX_LOADS = 4'h5;

   // =====================================================================
   // fault kinds reported to the core
   typedef enum logic [3:0] {
      BLC_FLT_NONE   = 4'h0,
      BLC_FLT_DBTRAP = 4'h1, // data/io/single-step/task-switch trap
      BLC_FLT_CODEBP = 4'h2,
      BLC_FLT_BP     = 4'h3,
      BLC_FLT_CP     = 4'h4,
      BLC_FLT_NM     = 4'h5,
      BLC_FLT_UD     = 4'h6,
      BLC_FLT_GD     = 4'h7,
      BLC_FLT_PF     = 4'h8, // lookup load fault, passed through
      BLC_FLT_GP     = 4'h9
   } blc_fault_e;

   // lookup sequencer, gray along idle->issue->wait
   typedef enum logic [1:0] {
      BLC_ST_IDLE  = 2'b00,
      BLC_ST_ISSUE = 2'b01,
      BLC_ST_WAIT  = 2'b11
   } blc_state_e;

   // per-privilege tracker state
   typedef struct packed {
      logic awaiting_landing;
      logic tracking_paused;
   } blc_trk_s;

   // instruction retiring this cycle
   typedef struct packed {
      logic valid;
      logic landing_marker_instr;
      logic breakpoint_instr;
      logic indirect_branch;
      logic no_track_prefix;
      logic xact_abort;
      logic irq_return_dbg;
      logic acm_entry;       // authenticated-code entry or secure launch
      logic acm_exit;
      logic dbg_trap_pend;
      logic code_bp_pend;
      logic gd_pend;
      logic nm_pend;
      logic ud_pend;
      logic is_load;
   } blc_instr_s;

   // per-privilege control bits
   typedef struct packed {
      logic tracking_enable;
      logic legacy_treatment_enable;
      logic no_pause_ctrl;
   } blc_ctrl_s;

   // bitmap byte load request
   typedef struct packed {
      logic        valid;
      logic [63:0] addr;
      logic        addr64;
      logic [1:0]  priv;
   } blc_ld_s;
endpackage

// ==== verilog/blc_trk_slot.sv ====
// one per-privilege tracker slot: awaiting and paused flags
module blc_trk_slot
   import blc_pkg::*;
(
   input  wire logic     ref_clk,
   input  wire logic     rst_b,
   input  wire logic     set_await,
   input  wire logic     go_idle,
   input  wire logic     set_pause,
   input  wire logic     clr_pause,
   output blc_trk_s      trk_ff
);
   // =====================================================================
   // tracker flags; idle wins so a clear never leaves a stale await
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         trk_ff <= '0;
      end else begin
         if (go_idle) begin
            trk_ff.awaiting_landing <= 1'b0;
         end else if (set_await) begin
            trk_ff.awaiting_landing <= 1'b1;
         end
         if (clr_pause) begin
            trk_ff.tracking_paused <= 1'b0;
         end else if (set_pause) begin
            trk_ff.tracking_paused <= 1'b1;
         end
      end
   end
endmodule

// ==== test/blc_core_tb.sv ====
// self-checking bench for the landing-marker enforcement unit
module blc_core_tb
   import blc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   `define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end

   // =====================================================================
   // port signals and capture registers
   logic         ref_clk, rst_b, ld_done, ld_fault, long_mode_active, code64, five_level_paging;
   logic         enclave_mode, enclave_opt_in, global_flow_protect_enable, cap_rst, cap_clr;
   logic         restart_ff, irq_window_block_ff, global_flow_clear_ff, spec_stall_ff;
   logic [1:0]   current_priv_level;
   logic [7:0]   ld_data, fault_code_ff, cap_c;
   logic [63:0]  enclave_base_addr, linear_instr_pointer, legacy_page_map_base, la;
   blc_instr_s   instr, x;
   blc_ctrl_s    user_ctrl, sup_ctrl;
   blc_ld_s      ld_req_ff, cap_ld;
   blc_fault_e   fault_ff, cap_f;
   blc_trk_s     user_trk_ff, sup_trk_ff;
   int           num_errors, comparisons;

   typedef struct packed {
      logic [6:0] flags; // breakpoint, marker, nm, ud, dbtrap, codebp, gd
      logic [1:0] encl;  // enclave mode, opt-in entry
      blc_fault_e exp;
      logic       busy;  // tracker still awaiting afterwards
   } blc_row_s;

   localparam blc_row_s ROWS [10] = '{
      '{7'h00, 2'b00, BLC_FLT_CP, 1'b1}, '{7'h20, 2'b00, BLC_FLT_NONE, 1'b0},
      '{7'h40, 2'b00, BLC_FLT_BP, 1'b1}, '{7'h10, 2'b00, BLC_FLT_CP, 1'b1},
      '{7'h08, 2'b00, BLC_FLT_CP, 1'b1}, '{7'h44, 2'b00, BLC_FLT_DBTRAP, 1'b1},
      '{7'h02, 2'b00, BLC_FLT_CODEBP, 1'b1}, '{7'h01, 2'b00, BLC_FLT_CP, 1'b1},
      '{7'h40, 2'b10, BLC_FLT_CP, 1'b1}, '{7'h40, 2'b11, BLC_FLT_BP, 1'b1}};
   localparam blc_instr_s IND   = '{valid: 1'b1, indirect_branch: 1'b1, default: 1'b0};
   localparam blc_instr_s PLAIN = '{valid: 1'b1, default: 1'b0};
   localparam blc_instr_s MARK  = '{valid: 1'b1, landing_marker_instr: 1'b1, default: 1'b0};
   localparam blc_instr_s ABORT = '{valid: 1'b1, xact_abort: 1'b1, default: 1'b0};
   localparam blc_instr_s ENTRY = '{valid: 1'b1, acm_entry: 1'b1, default: 1'b0};
   localparam blc_instr_s EXIT  = '{valid: 1'b1, acm_exit: 1'b1, default: 1'b0};
   localparam blc_instr_s DRET  = '{valid: 1'b1, irq_return_dbg: 1'b1, default: 1'b0};

   blc_core u_blc_core (
      .ref_clk, .rst_b, .instr, .current_priv_level, .user_ctrl, .sup_ctrl, .global_flow_protect_enable,
      .long_mode_active, .code64, .five_level_paging, .enclave_mode, .enclave_opt_in, .enclave_base_addr,
      .linear_instr_pointer, .legacy_page_map_base, .ld_done, .ld_fault, .ld_data, .ld_req_ff, .fault_ff,
      .fault_code_ff, .restart_ff, .irq_window_block_ff, .global_flow_clear_ff, .spec_stall_ff,
      .user_trk_ff, .sup_trk_ff
   );

   // =====================================================================
   // 40 mhz clock and a watchdog so a stuck run still reports
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      #1ms;
      num_errors++;
      summarize();
   end

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // one instruction and/or load answer, then four cycles of watching the pulses
   task automatic step(input blc_instr_s i, input logic d, input logic f, input logic [7:0] dat);
      @(negedge ref_clk);
      instr = i;
      ld_done = d;
      ld_fault = f;
      ld_data = dat;
      cap_f = BLC_FLT_NONE;
      {cap_c, cap_rst, cap_clr, cap_ld} = '0;
      repeat (4) begin
         @(negedge ref_clk);
         instr = '0;
         ld_done = 1'b0;
         ld_fault = 1'b0;
         ld_data = ~dat; // return bus never keeps the last byte
         if (fault_ff !== BLC_FLT_NONE && cap_f === BLC_FLT_NONE) begin
            cap_f = fault_ff;
            cap_c = fault_code_ff;
         end
         if (ld_req_ff.valid === 1'b1) cap_ld = ld_req_ff;
         cap_rst |= (restart_ff === 1'b1 && irq_window_block_ff === 1'b1); // restart with window shut
         cap_clr |= (global_flow_clear_ff === 1'b1);
      end
   endtask

   // =====================================================================
   // main sequence: reset, priority table, then the lookup paths
   initial begin
      {rst_b, ld_done, ld_fault, ld_data, instr, sup_ctrl} = '0;
      {long_mode_active, code64, five_level_paging, enclave_mode, enclave_opt_in} = '0;
      {num_errors, comparisons} = '0;
      global_flow_protect_enable = 1'b1; // tracking needs the global enable
      current_priv_level = PRIV_USER;
      user_ctrl = 3'b100; // tracking on, legacy treatment off
      enclave_base_addr = 64'h0000_0000_1000_0000;
      linear_instr_pointer = 64'h0000_5a5a_1234_6000;
      legacy_page_map_base = 64'h0000_0001_ffff_0000;
      repeat (4) @(negedge ref_clk);
      `CHK({user_trk_ff, sup_trk_ff, fault_ff, restart_ff}, '0)
      rst_b = 1'b1;
      $display("test reset done");
      foreach (ROWS[n]) begin
         x = PLAIN;
         {x.breakpoint_instr, x.landing_marker_instr, x.nm_pend, x.ud_pend} = ROWS[n].flags[6:3];
         {x.dbg_trap_pend, x.code_bp_pend, x.gd_pend} = ROWS[n].flags[2:0];
         {enclave_mode, enclave_opt_in} = ROWS[n].encl;
         step(IND, 1'b0, 1'b0, 8'h00);
         `CHK(user_trk_ff, 2'b10)
         step(x, 1'b0, 1'b0, 8'h00);
         `CHK(cap_f, ROWS[n].exp)
         `CHK(cap_c, (ROWS[n].exp == BLC_FLT_BP) ? BP_VECTOR : GP_CODE_ZERO)
         `CHK(user_trk_ff.awaiting_landing, ROWS[n].busy)
         step(ABORT, 1'b0, 1'b0, 8'h00);
         `CHK(user_trk_ff, 2'b00)
      end
      // opt-out enclave breakpoint with the tracker idle is an undefined opcode
      {enclave_mode, enclave_opt_in} = 2'b10;
      x = PLAIN;
      x.breakpoint_instr = 1'b1;
      step(x, 1'b0, 1'b0, 8'h00);
      `CHK(cap_f, BLC_FLT_UD)
      {enclave_mode, enclave_opt_in} = 2'b00;
      $display("test priority table done");
      // allowed legacy transfer in 64-bit code, four-level paging
      {user_ctrl, long_mode_active, code64} = {3'b110, 2'b11};
      step(IND, 1'b0, 1'b0, 8'h00);
      step(PLAIN, 1'b0, 1'b0, 8'h00);
      `CHK(cap_ld, {1'b1, legacy_page_map_base + 64'(linear_instr_pointer[47:15]), 1'b1, PRIV_USER})
      `CHK(cap_f, BLC_FLT_NONE)
      step('0, 1'b1, 1'b0, 8'h40);
      `CHK({cap_rst, cap_f}, {1'b1, BLC_FLT_NONE})
      `CHK(user_trk_ff, 2'b01)
      step(IND, 1'b0, 1'b0, 8'h00);
      `CHK(user_trk_ff, 2'b01)
      step(MARK, 1'b0, 1'b0, 8'h00);
      `CHK(user_trk_ff, 2'b00)
      $display("test legacy allowed done");
      // refused transfer, 32-bit enclave code, sum wraps past 32 bits
      {long_mode_active, code64, enclave_mode, enclave_opt_in} = 4'b0011;
      linear_instr_pointer = 64'h0000_0000_9876_5000;
      la = linear_instr_pointer - enclave_base_addr;
      step(IND, 1'b0, 1'b0, 8'h00);
      step(PLAIN, 1'b0, 1'b0, 8'h00);
      `CHK(cap_ld, {1'b1, 64'(32'(legacy_page_map_base + 64'(la[31:15]))), 1'b0, PRIV_USER})
      step('0, 1'b1, 1'b0, 8'hdf);
      `CHK({cap_rst, cap_f}, {1'b0, BLC_FLT_CP})
      `CHK(user_trk_ff, 2'b10)
      $display("test legacy refused done");
      // supervisor lookup with five-level paging, load faults
      {current_priv_level, sup_ctrl, five_level_paging, code64, long_mode_active} = {2'h0, 3'b111, 3'b111};
      {enclave_mode, enclave_opt_in} = 2'b00;
      linear_instr_pointer = 64'h0123_4567_89ab_c000;
      step(IND, 1'b0, 1'b0, 8'h00);
      step(PLAIN, 1'b0, 1'b0, 8'h00);
      `CHK(cap_ld, {1'b1, legacy_page_map_base + 64'(linear_instr_pointer[56:15]), 1'b1, 2'h0})
      step('0, 1'b0, 1'b1, 8'h00);
      `CHK({cap_rst, cap_f}, {1'b0, BLC_FLT_PF})
      `CHK(sup_trk_ff, 2'b10)
      step(ABORT, 1'b0, 1'b0, 8'h00);
      `CHK({sup_trk_ff, user_trk_ff}, 4'h0)
      $display("test lookup fault done");
      // secure launch and debug-handler return
      {current_priv_level, global_flow_protect_enable} = {PRIV_USER, 1'b1};
      step(ENTRY, 1'b0, 1'b0, 8'h00);
      `CHK(cap_clr, 1'b1)
      step(EXIT, 1'b0, 1'b0, 8'h00);
      `CHK({cap_f, cap_c}, {BLC_FLT_GP, GP_CODE_ZERO})
      step(DRET, 1'b0, 1'b0, 8'h00);
      `CHK(user_trk_ff, 2'b10)
      $display("test launch and return done");
      // loads past a missing marker: the fifth one raises the stall
      user_ctrl = 3'b100;
      x = PLAIN;
      x.is_load = 1'b1;
      repeat (4) step(x, 1'b0, 1'b0, 8'h00);
      `CHK(spec_stall_ff, 1'b0)
      step(x, 1'b0, 1'b0, 8'h00);
      `CHK(spec_stall_ff, 1'b1)
      step(ABORT, 1'b0, 1'b0, 8'h00);
      `CHK(spec_stall_ff, 1'b0)
      $display("test speculation limit done");
      summarize();
   end
endmodule
